// file: bench/rtc_irq_comp_bench.sv
// Self-checking bench for the RTC interrupt and drift block.
// Assumes the design package and a fast osc32k toggled by the bench.

`timescale 1ns/1ps

module rtc_irq_comp_bench
	import rtc_pkg::*;
;
	logic       core_clk    = 1'b0;
	logic       rst_n       = 1'b0;
	logic       osc32k      = 1'b0;
	logic       sleep_state = 1'b0;
	logic [4:0] addr        = 5'h00;
	logic [7:0] wdata       = 8'h00;
	logic       wr          = 1'b0;
	logic       rd          = 1'b0;
	wire  [7:0] rdata;
	wire        irq;
	int         mismatches  = 0;
	int         cmp_count   = 0;
	logic       mask_on     = 1'b1;

	always #25 core_clk = ~core_clk;

	rtc_irq_comp dut (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.osc32k     (osc32k),
		.sleep_state(sleep_state),
		.addr       (addr),
		.wdata      (wdata),
		.wr         (wr),
		.rd         (rd),
		.rdata      (rdata),
		.irq        (irq)
	);

	// ---------------------------------------------------------------
	// Access tasks
	// ---------------------------------------------------------------
	task automatic stop_test();
		$display("Compared %0d, mismatched %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(string name, logic [7:0] got, logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr_reg(logic [4:0] a, logic [7:0] v);
		@(posedge core_clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge core_clk);
		wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(string name, logic [4:0] a, logic [7:0] exp);
		@(posedge core_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge core_clk);
		rd   <= 1'b0;
		@(negedge core_clk);
		check(name, rdata, exp);
	endtask

	// Each pulse is one sub-second count after the two-flop sync
	task automatic osc(int n);
		repeat (n) begin
			repeat (4) @(posedge core_clk);
			osc32k <= 1'b1;
			repeat (4) @(posedge core_clk);
			osc32k <= 1'b0;
		end
		repeat (6) @(posedge core_clk);
	endtask

	// Preload only with the clock halted
	task automatic preload(logic [15:0] v);
		wr_reg(A_CTRL, 8'h00);
		rd_chk("halted", A_STAT, 8'h00);
		wr_reg(A_CLSB, v[7:0]);
		wr_reg(A_CMSB, v[15:8]);
		wr_reg(A_CTRL, 8'h04);
	endtask

	task automatic set_time(logic [7:0] h, logic [7:0] m, logic [7:0] s);
		wr_reg(A_TC0 + 5'h02, h);
		wr_reg(A_TC0 + 5'h01, m);
		wr_reg(A_TC0, s);
	endtask

	task automatic comp_case(logic [7:0] ctl, logic [7:0] s0,
		logic [15:0] pre, logic [15:0] comp, int n, logic [7:0] exp);
		preload(pre);
		set_time(8'h00, 8'h00, s0);
		wr_reg(A_CLSB, comp[7:0]);
		wr_reg(A_CMSB, comp[15:8]);
		wr_reg(A_CTRL, ctl);
		osc(n);
		rd_chk("seconds", A_TC0, exp);
	endtask

	// One nominal second from a preload two counts short of the end
	task automatic tick_case(logic [7:0] ictl, logic [7:0] h,
		logic [7:0] m, logic [7:0] s, logic [7:0] exp);
		wr_reg(A_IST, 8'h03);
		wr_reg(A_ICTL, ictl);
		preload(16'h7ffe);
		set_time(h, m, s);
		wr_reg(A_CTRL, 8'h01);
		osc(2);
		rd_chk("irq status", A_IST, exp);
		check("irq", {7'h00, irq}, {7'h00, exp != 8'h00 && mask_on});
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);

		rd_chk("seconds", A_TC0, 8'h00);
		rd_chk("day", A_TC0 + 5'h03, 8'h01);
		rd_chk("alarm month", A_AL0 + 5'h04, 8'h01);
		rd_chk("control", A_CTRL, 8'h00);
		rd_chk("irq control", A_ICTL, 8'h00);
		check("irq", {7'h00, irq}, 8'h00);
		wr_reg(5'h1f, 8'hff);
		rd_chk("unmapped", 5'h1f, 8'h00);
		$display("Reset and map test done");

		wr_reg(A_CTRL, 8'h01);
		rd_chk("running", A_STAT, 8'h01);
		wr_reg(A_CTRL, 8'h00);
		rd_chk("halted", A_STAT, 8'h00);
		comp_case(8'h01, 8'h05, 16'h7ffe, 16'h7ffe, 1, 8'h05);
		osc(1);
		rd_chk("seconds", A_TC0, 8'h06);
		$display("Run and preload test done");

		comp_case(8'h03, 8'h01, 16'h0000, 16'h7ff0, 15, 8'h01);
		comp_case(8'h03, 8'h01, 16'h0000, 16'h7ff0, 16, 8'h02);
		comp_case(8'h03, 8'h02, 16'h0000, 16'h7ff0, 16, 8'h02);
		comp_case(8'h01, 8'h01, 16'h0000, 16'h7ff0, 16, 8'h01);
		comp_case(8'h03, 8'h01, 16'h7ffe, 16'hfff0, 17, 8'h01);
		comp_case(8'h03, 8'h01, 16'h7ffe, 16'hfff0, 18, 8'h02);
		$display("Compensation test done");

		wr_reg(A_IMSK, 8'h03);
		wr_reg(A_AL0, 8'h06);
		tick_case(8'h00, 8'h00, 8'h00, 8'h05, 8'h00);
		tick_case(8'h08, 8'h00, 8'h00, 8'h05, 8'h01);
		wr_reg(A_IST, 8'h01);
		rd_chk("alarm cleared", A_IST, 8'h00);
		$display("Alarm test done");

		for (int p = 4; p < 8; p++)
			tick_case(p[7:0], 8'h23, 8'h59, 8'h59, 8'h02);
		tick_case(8'h05, 8'h00, 8'h00, 8'h58, 8'h00);
		tick_case(8'h07, 8'h00, 8'h59, 8'h59, 8'h00);
		tick_case(8'h06, 8'h00, 8'h00, 8'h59, 8'h00);
		tick_case(8'h00, 8'h00, 8'h00, 8'h10, 8'h00);
		wr_reg(A_IMSK, 8'h00);
		mask_on = 1'b0;
		tick_case(8'h04, 8'h00, 8'h00, 8'h20, 8'h02);
		check("masked irq", {7'h00, irq}, 8'h00);
		wr_reg(A_IMSK, 8'h03);
		mask_on = 1'b1;
		$display("Tick test done");

		@(posedge core_clk);
		sleep_state <= 1'b1;
		tick_case(8'h14, 8'h00, 8'h00, 8'h30, 8'h00);
		@(posedge core_clk);
		sleep_state <= 1'b0;
		for (int i = 0; i <= 20 && irq !== 1'b1; i++) begin
			if (i == 20)
				check("held tick irq", {7'h00, irq}, 8'h01);
			@(posedge core_clk);
		end
		rd_chk("held tick", A_IST, 8'h02);
		@(posedge core_clk);
		sleep_state <= 1'b1;
		tick_case(8'h04, 8'h00, 8'h00, 8'h40, 8'h02);
		@(posedge core_clk);
		sleep_state <= 1'b0;
		$display("Sleep hold test done");
		stop_test();
	end
endmodule

// file: verilog/rtc_irq_comp.sv
// Time keeping, alarm and tick events, once-a-minute drift compensation.
// Assumes osc32k and sleep_state are asynchronous pins; registers are
// reached over a plain strobe port on core_clk.

`timescale 1ns/1ps

module rtc_irq_comp
	import rtc_pkg::*;
(
	input  wire logic       core_clk,    // 20 MHz system clock
	input  wire logic       rst_n,       // Async reset, active low
	input  wire logic       osc32k,      // 32-kHz reference pin
	input  wire logic       sleep_state, // High while device in sleep
	input  wire logic [4:0] addr,        // Register index
	input  wire logic [7:0] wdata,       // Write data
	input  wire logic       wr,          // Write strobe
	input  wire logic       rd,          // Read strobe
	output logic      [7:0] rdata,       // Read data, cycle after rd
	output logic            irq          // Level interrupt
);

	// ---------------------------------------------------------------
	// Reset and pin synchronisers
	// ---------------------------------------------------------------
	logic       rst_m_r;
	logic       rst_s_n;
	logic [2:0] osc_r;
	logic [1:0] slp_r;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_r <= 1'b0;
			rst_s_n <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_s_n <= rst_m_r;
		end
	end

	// Third stage only feeds the edge detector, never the first
	always_ff @(posedge core_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			osc_r <= 3'h0;
			slp_r <= 2'h0;
		end else begin
			osc_r <= {osc_r[1:0], osc32k};
			slp_r <= {slp_r[0], sleep_state};
		end
	end

	wire tick32  = osc_r[1] & ~osc_r[2];
	wire sleep_s = slp_r[1];

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [5:0][7:0] tc_r;
	logic [5:0][7:0] al_r;
	logic [5:0][7:0] tc_adv;
	logic            run_r;
	logic            comp_en_r;
	logic            running_r;
	rtc_ictl_t       ictl_r;
	logic [15:0]     comp_r;
	logic [15:0]     sub_r;
	logic [1:0]      ist_r;
	logic [1:0]      imsk_r;
	logic            pend_r;
	logic            match_r;
	logic [7:0]      rd_mux;

	wire wr_ctrl = wr && (addr == A_CTRL);
	wire wr_ictl = wr && (addr == A_ICTL);
	wire wr_clsb = wr && (addr == A_CLSB);
	wire wr_cmsb = wr && (addr == A_CMSB);
	wire wr_ist  = wr && (addr == A_IST);
	wire wr_imsk = wr && (addr == A_IMSK);
	wire preload = wr_ctrl && wdata[CTRL_LOAD];

	// ---------------------------------------------------------------
	// BCD helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		if (v[3:0] == 4'h9)
			r = {v[7:4] + 4'h1, 4'h0};
		else
			r = {v[7:4], v[3:0] + 4'h1};
		return r;
	endfunction

	// BCD year divisible by four
	wire [3:0] yr_lo = tc_r[5][3:0];
	wire leap = tc_r[5][4]
		? (yr_lo == 4'h2 || yr_lo == 4'h6)
		: (yr_lo == 4'h0 || yr_lo == 4'h4 || yr_lo == 4'h8);

	wire [7:0] mon = tc_r[4];
	wire short_mon = (mon == 8'h04) || (mon == 8'h06) ||
		(mon == 8'h09) || (mon == 8'h11);
	wire [7:0] day_max = (mon == 8'h02) ? (leap ? 8'h29 : 8'h28)
		: (short_mon ? 8'h30 : 8'h31);

	// ---------------------------------------------------------------
	// Second counter with once-a-minute adjustment
	// ---------------------------------------------------------------
	// Adjusted window is the second running from second 1 to 2;
	// its length is re-read every cycle, so late writes still land.
	wire        adj_win = comp_en_r && (tc_r[0] == 8'h01);
	wire [16:0] comp_sx = {comp_r[15], comp_r};
	wire [16:0] sec_len = adj_win ? (SUB_NOM - comp_sx)
		: SUB_NOM;
	wire [16:0] sub_p1  = {1'b0, sub_r} + 17'h00001;
	wire        sec_end = running_r && tick32 && (sub_p1 >= sec_len);

	always_ff @(posedge core_clk or negedge rst_s_n) begin
		if (!rst_s_n)
			sub_r <= 16'h0000;
		else if (preload)
			sub_r <= comp_r;
		else if (sec_end)
			sub_r <= 16'h0000;
		else if (running_r && tick32)
			sub_r <= sub_p1[15:0];
	end

	// ---------------------------------------------------------------
	// Calendar advance
	// ---------------------------------------------------------------
	wire sec_wrap = tc_r[0] == SEC_MAX;
	wire min_wrap = sec_wrap && (tc_r[1] == SEC_MAX);
	wire hr_wrap  = min_wrap && (tc_r[2] == HR_MAX);
	wire day_wrap = hr_wrap && (tc_r[3] == day_max);
	wire mon_wrap = day_wrap && (tc_r[4] == MON_MAX);

	always_comb begin
		tc_adv = tc_r;
		tc_adv[0] = sec_wrap ? 8'h00 : bcd_inc(tc_r[0]);
		if (sec_wrap)
			tc_adv[1] = min_wrap ? 8'h00 : bcd_inc(tc_r[1]);
		if (min_wrap)
			tc_adv[2] = hr_wrap ? 8'h00 : bcd_inc(tc_r[2]);
		if (hr_wrap)
			tc_adv[3] = day_wrap ? 8'h01 : bcd_inc(tc_r[3]);
		if (day_wrap)
			tc_adv[4] = mon_wrap ? 8'h01 : bcd_inc(tc_r[4]);
		if (mon_wrap)
			tc_adv[5] = (tc_r[5] == 8'h99) ? 8'h00 : bcd_inc(tc_r[5]);
	end

	// Bus write to a field wins over the advance in the same cycle
	generate
		for (genvar i = 0; i < 6; i++) begin : g_field
			wire tc_wr = wr && (addr == A_TC0 + 5'(i));
			wire al_wr = wr && (addr == A_AL0 + 5'(i));
			always_ff @(posedge core_clk or negedge rst_s_n) begin
				if (!rst_s_n) begin
					tc_r[i] <= RST_TC[i*8 +: 8];
					al_r[i] <= RST_TC[i*8 +: 8];
				end else begin
					if (tc_wr)
						tc_r[i] <= wdata;
					else if (sec_end)
						tc_r[i] <= tc_adv[i];
					if (al_wr)
						al_r[i] <= wdata;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Control registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			run_r     <= 1'b0;
			comp_en_r <= 1'b0;
			running_r <= 1'b0;
			ictl_r    <= RST_ICTL;
			comp_r    <= 16'h0000;
			imsk_r    <= 2'h0;
		end else begin
			running_r <= run_r;
			if (wr_ctrl) begin
				run_r     <= wdata[CTRL_RUN];
				comp_en_r <= wdata[CTRL_COMP];
			end
			if (wr_ictl)
				ictl_r <= rtc_ictl_t'(wdata[4:0]);
			// No shadowing: a half-written value is used as is
			if (wr_clsb)
				comp_r[7:0] <= wdata;
			if (wr_cmsb)
				comp_r[15:8] <= wdata;
			if (wr_imsk)
				imsk_r <= wdata[1:0];
		end
	end

	// ---------------------------------------------------------------
	// Events
	// ---------------------------------------------------------------
	wire match     = (tc_r == al_r);
	wire alarm_evt = ictl_r.alarm_en && match && !match_r;

	logic per_hit;
	always_comb begin
		case (ictl_r.period)
			PER_SEC:  per_hit = 1'b1;
			PER_MIN:  per_hit = sec_wrap;
			PER_HOUR: per_hit = min_wrap;
			PER_DAY:  per_hit = hr_wrap;
			default:  per_hit = 1'b0;
		endcase
	end

	wire tick_raw  = sec_end && per_hit && ictl_r.tick_en;
	wire hold      = sleep_s && ictl_r.hold_en;
	wire tick_fire = (tick_raw && !hold) ||
		(pend_r && !sleep_s);

	always_ff @(posedge core_clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			match_r <= 1'b0;
			pend_r  <= 1'b0;
		end else begin
			match_r <= match;
			if (tick_raw && hold)
				pend_r <= 1'b1;
			else if (!sleep_s)
				pend_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status
	// ---------------------------------------------------------------
	// A new event in the clearing cycle keeps its flag set
	wire [1:0] ist_clr = wr_ist ? wdata[1:0] : 2'h0;
	wire [1:0] ist_set = {tick_fire, alarm_evt};

	always_ff @(posedge core_clk or negedge rst_s_n) begin
		if (!rst_s_n)
			ist_r <= 2'h0;
		else
			ist_r <= (ist_r & ~ist_clr) | ist_set;
	end

	assign irq = |(ist_r & imsk_r);

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	always_comb begin
		rd_mux = 8'h00;
		if (addr < A_TC0 + 5'h06)
			rd_mux = tc_r[addr[2:0]];
		else if (addr >= A_AL0 && addr < A_AL0 + 5'h06)
			rd_mux = al_r[addr[2:0]];
		else begin
			case (addr)
				A_CTRL:  rd_mux = {6'h00, comp_en_r, run_r};
				A_STAT:  rd_mux = {7'h00, running_r};
				A_ICTL:  rd_mux = {3'h0, ictl_r};
				A_CLSB:  rd_mux = comp_r[7:0];
				A_CMSB:  rd_mux = comp_r[15:8];
				A_IST:   rd_mux = {6'h00, ist_r};
				A_IMSK:  rd_mux = {6'h00, imsk_r};
				default: rd_mux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_s_n) begin
		if (!rst_s_n)
			rdata <= 8'h00;
		else
			rdata <= rd ? rd_mux : 8'h00;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_alarm_sets: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		alarm_evt |=> ist_r[IRQ_ALARM])
		else $error("alarm event did not set status");

	a_alarm_gated: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		!ictl_r.alarm_en && !$past(ist_r[IRQ_ALARM]) && !wr_ist
		|-> !ist_r[IRQ_ALARM] || $past(alarm_evt))
		else $error("alarm flag set while alarm disabled");

	a_tick_enable: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		sec_end && !ictl_r.tick_en && !pend_r |=> !pend_r)
		else $error("tick recorded while tick disabled");

	a_sleep_hold: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		tick_raw && hold |=> pend_r)
		else $error("held tick not recorded in sleep");

	a_hold_deliver: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		pend_r && !sleep_s |=> ist_r[IRQ_TICK] && !pend_r)
		else $error("pending tick not delivered after sleep");

	a_nominal_sec: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		sec_end && !comp_en_r && !preload |-> sub_r >= 16'h7fff)
		else $error("second shorter than nominal count");

	a_adjust_len: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		sec_end && tc_r[0] == 8'h01 && comp_en_r
		|-> {1'b0, sub_r} + 17'h1 >= SUB_NOM - comp_sx)
		else $error("adjusted second ended early");

	a_preload_val: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		preload && !wr_clsb && !wr_cmsb |=> sub_r == $past(comp_r))
		else $error("preload did not load compensation value");

	a_run_status: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		!run_r ##1 !run_r |-> !running_r ##1 $stable(sub_r) || $past(preload))
		else $error("halted clock still counting");

	a_alarm_bcd: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		g_field[0].al_wr && wdata[3:0] <= 4'h9 |=> al_r[0][3:0] <= 4'h9)
		else $error("alarm seconds not held as written");

	a_irq_level: assert property (@(posedge core_clk)
		disable iff (!rst_s_n)
		ist_set[IRQ_TICK] && imsk_r[IRQ_TICK] && !wr_imsk |=> irq)
		else $error("unmasked tick did not raise interrupt");

endmodule

// file: verilog/rtc_pkg.sv
// Constants, types and register map of the RTC interrupt and drift block.
// Assumes an 8-bit register port and a 32-kHz reference on a pin.

package rtc_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [4:0] A_TC0  = 5'h00;
	localparam logic [4:0] A_AL0  = 5'h08;
	localparam logic [4:0] A_CTRL = 5'h10;
	localparam logic [4:0] A_STAT = 5'h11;
	localparam logic [4:0] A_ICTL = 5'h12;
	localparam logic [4:0] A_CLSB = 5'h13;
	localparam logic [4:0] A_CMSB = 5'h14;
	localparam logic [4:0] A_IST  = 5'h15;
	localparam logic [4:0] A_IMSK = 5'h16;

	localparam int CTRL_RUN  = 0;
	localparam int CTRL_COMP = 1;
	localparam int CTRL_LOAD = 2;
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_TICK  = 1;

	// ---------------------------------------------------------------
	// Reset values and limits
	// ---------------------------------------------------------------
	localparam logic [47:0] RST_TC   = 48'h00_01_01_00_00_00;
	localparam logic [7:0]  SEC_MAX  = 8'h59;
	localparam logic [7:0]  HR_MAX   = 8'h23;
	localparam logic [7:0]  MON_MAX  = 8'h12;
	localparam logic [16:0] SUB_NOM  = 17'h08000;

	typedef enum logic [1:0] {
		PER_SEC,
		PER_MIN,
		PER_HOUR,
		PER_DAY
	} rtc_per_t;

	typedef struct packed {
		logic     hold_en;
		logic     alarm_en;
		logic     tick_en;
		rtc_per_t period;
	} rtc_ictl_t;

	localparam rtc_ictl_t RST_ICTL = 5'h00;

endpackage
